// [rtl/hmul_core.sv]
// Single cycle 8x8 unsigned multiplier with product register pair
// Notes on behaviour
// - Unsigned operands, full 16-bit product kept.
// - Product ready for the very next instruction.
// - Upper byte high register, lower byte low.
// - Multiply leaves the ALU flags unchanged.
// - Operands: working register and addressed file.
`timescale 1ns/1ns
`include "hmul_defines.svh"

module hmul_core
(
    // Clock and reset
    input  wire logic                    i_clk_sys,           // Core clock, 250 MHz
    input  wire logic                    i_reset,             // Synchronous reset, high
    // Multiply instruction from the decoder
    input  wire logic                    i_mul_go,            // Execute multiply this cycle
    input  wire hmul_pkg::hmul_byte_type i_working_register,  // Working operand
    input  wire hmul_pkg::hmul_byte_type i_file_operand,      // Addressed file operand
    // Direct writes to the product pair and the flags
    input  wire logic                    i_wr_prod_hi,        // Software write high byte
    input  wire logic                    i_wr_prod_lo,        // Software write low byte
    input  wire logic                    i_wr_flags,          // ALU writes flag register
    input  wire hmul_pkg::hmul_byte_type i_wr_data,           // Data for software writes
    // Registered results
    output logic [7:0]                   o_product_high_byte, // Product high byte
    output logic [7:0]                   o_product_low_byte,  // Product low byte
    output logic [7:0]                   o_alu_flag_register  // ALU flags
);
    import hmul_pkg::*;

    // ------------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------------
    // The whole block state is one packed struct: both product
    // bytes and the flag register live together in state_ff
    hmul_state_type state_ff;                       // Registered state
    hmul_state_type nxt_state;                      // Next state
    hmul_prod_type  product;                        // Combinational product

    // Unsigned 8x8 multiply, zero-extended so nothing is truncated
    // Both operands are widened before the multiply, so the top
    // eight bits of the result are never lost to a narrow context
    function automatic hmul_prod_type hmul_umul(input hmul_byte_type a, input hmul_byte_type b);
        hmul_prod_type r;
        r = hmul_prod_type'(a) * hmul_prod_type'(b);
        return r;
    endfunction : hmul_umul

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // The decoder offers at most one multiply per cycle; the product
    // reaches the pair at the edge that ends the instruction, so the
    // very next instruction can already move it elsewhere.
    // Byte and flag writes offered in a multiply cycle are dropped.
    always_comb
    begin
        nxt_state = state_ff;
        product   = hmul_umul(i_working_register, i_file_operand);
        // Multiply has priority over a same-cycle byte write
        if (i_mul_go)
        begin
            nxt_state.prod_hi = product[15:8];
            nxt_state.prod_lo = product[7:0];
        end
        else
        begin
            // Explicit writes only, else product is held
            if (i_wr_prod_hi)
                nxt_state.prod_hi = i_wr_data;
            if (i_wr_prod_lo)
                nxt_state.prod_lo = i_wr_data;
        end
        // Flags change only on ALU flag writes, never on multiply
        if (i_wr_flags && !i_mul_go)
            nxt_state.flags = i_wr_data;
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    // Synchronous reset clears the pair and the flags; otherwise
    // the next state computed above is taken on every edge
    always_ff @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            state_ff.prod_hi <= `HMUL_PROD_RST;
            state_ff.prod_lo <= `HMUL_PROD_RST;
            state_ff.flags   <= `HMUL_FLAG_RST;
        end
        else
            state_ff <= nxt_state;
    end

    // Outputs are plain wires from the state flip-flops
    assign o_product_high_byte = state_ff.prod_hi;
    assign o_product_low_byte  = state_ff.prod_lo;
    assign o_alu_flag_register = state_ff.flags;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    // All checks run on the core clock and are switched off
    // while reset is held
    // A multiply instruction offered this cycle
    sequence s_mul;
        i_mul_go;
    endsequence

    property p_full_product;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_mul |=> {o_product_high_byte, o_product_low_byte} ==
                  16'($past(i_working_register)) * 16'($past(i_file_operand));
    endproperty
    a_full_product: assert property (p_full_product) else $error("product wrong");

    property p_next_cycle;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_mul |-> ##1 o_product_low_byte == 8'($past(i_working_register) * $past(i_file_operand));
    endproperty
    a_next_cycle: assert property (p_next_cycle) else $error("product late");

    property p_high_byte;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_mul |=> o_product_high_byte == 8'((16'($past(i_working_register)) *
                                            16'($past(i_file_operand))) >> 8);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte wrong");

    property p_flags_kept;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_mul |=> $stable(o_alu_flag_register);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

    property p_operands;
        @(posedge i_clk_sys) disable iff (i_reset)
        (i_mul_go && i_file_operand == 8'h01) |=> o_product_low_byte == $past(i_working_register);
    endproperty
    a_operands: assert property (p_operands) else $error("operand source wrong");

    property p_hold;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!i_mul_go && !i_wr_prod_hi && !i_wr_prod_lo) |=>
            $stable(o_product_high_byte) && $stable(o_product_low_byte);
    endproperty
    a_hold: assert property (p_hold) else $error("product not held");

    property p_write;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!i_mul_go && i_wr_prod_lo) |=> o_product_low_byte == $past(i_wr_data);
    endproperty
    a_write: assert property (p_write) else $error("low byte write lost");

    property p_flag_write;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!i_mul_go && i_wr_flags) |=> o_alu_flag_register == $past(i_wr_data);
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag write lost");

    // A high byte write on its own lands and leaves the low byte alone
    sequence s_write_hi_only;
        !i_mul_go && i_wr_prod_hi && !i_wr_prod_lo;
    endsequence

    property p_write_hi;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_hi_only |=> o_product_high_byte == $past(i_wr_data) && $stable(o_product_low_byte);
    endproperty
    a_write_hi: assert property (p_write_hi) else $error("high byte write lost");

    // A low byte write on its own leaves the high byte alone
    sequence s_write_lo_only;
        !i_mul_go && i_wr_prod_lo && !i_wr_prod_hi;
    endsequence

    property p_write_lo_keeps_hi;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_lo_only |=> $stable(o_product_high_byte);
    endproperty
    a_write_lo_keeps_hi: assert property (p_write_lo_keeps_hi) else $error("high byte disturbed");

    // A multiply in the same cycle as a byte write keeps the product
    sequence s_mul_with_write;
        i_mul_go && (i_wr_prod_hi || i_wr_prod_lo);
    endsequence

    property p_mul_wins;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_mul_with_write |=> {o_product_high_byte, o_product_low_byte} ==
                             16'($past(i_working_register)) * 16'($past(i_file_operand));
    endproperty
    a_mul_wins: assert property (p_mul_wins) else $error("write beat multiply");

    // Flags move only on an accepted flag write
    property p_flags_hold;
        @(posedge i_clk_sys) disable iff (i_reset)
        (!i_wr_flags || i_mul_go) |=> $stable(o_alu_flag_register);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved without write");

    // A zero operand gives a zero product in the next cycle
    sequence s_mul_by_zero;
        i_mul_go && (i_working_register == 8'h00 || i_file_operand == 8'h00);
    endsequence

    property p_zero_product;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_mul_by_zero |=> o_product_high_byte == 8'h00 && o_product_low_byte == 8'h00;
    endproperty
    a_zero_product: assert property (p_zero_product) else $error("zero operand product wrong");

    // Largest operands give the largest product, nothing cut off
    sequence s_mul_max;
        i_mul_go && i_working_register == 8'hFF && i_file_operand == 8'hFF;
    endsequence

    property p_max_product;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_mul_max |=> o_product_high_byte == 8'hFE && o_product_low_byte == 8'h01;
    endproperty
    a_max_product: assert property (p_max_product) else $error("largest product cut");

endmodule : hmul_core

// [rtl/hmul_defines.svh]
// Constants for the single cycle 8x8 hardware multiplier
`ifndef HMUL_DEFINES_SVH
`define HMUL_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define HMUL_OPND_W      8
`define HMUL_PROD_W      16
`define HMUL_PROD_RST    8'h00
`define HMUL_FLAG_W      8
`define HMUL_FLAG_RST    8'h00

`endif

// [rtl/hmul_pkg.sv]
// Types for the single cycle 8x8 hardware multiplier
`include "hmul_defines.svh"

package hmul_pkg;

    // ------------------------------------------------------------------------
    // Operand, product and block state types
    // ------------------------------------------------------------------------
    typedef logic [`HMUL_OPND_W-1:0] hmul_byte_type;   // One operand byte
    typedef logic [`HMUL_PROD_W-1:0] hmul_prod_type;   // Full product

    typedef struct packed
    {
        hmul_byte_type prod_hi;                        // Product high byte
        hmul_byte_type prod_lo;                        // Product low byte
        hmul_byte_type flags;                          // ALU flag register
    } hmul_state_type;

endpackage : hmul_pkg

// [verification/hmul_cpu_model.sv]
// Core-side model that issues multiply and write instructions
`timescale 1ns/1ns
module hmul_cpu_model
(
    input  wire logic               i_clk_sys, // Core clock
    output hmul_pkg::hmul_byte_type o_w,       // Working operand
    output hmul_pkg::hmul_byte_type o_f,       // File operand
    output logic [3:0]              o_ctl,     // Go, write high, low, flags
    output hmul_pkg::hmul_byte_type o_d        // Write data
);
    import hmul_pkg::*;
    initial {o_ctl, o_w, o_f, o_d} = '0;
    // One instruction per edge; unused lines flip so stale values never match
    task automatic op(input logic [3:0] c, input hmul_byte_type w, f, d);
        @(posedge i_clk_sys);
        o_ctl <= c;
        o_w   <= c[3] ? w : ~o_w;
        o_f   <= c[3] ? f : ~o_f;
        o_d   <= |c[2:0] ? d : ~o_d;
        #1;
    endtask : op
endmodule : hmul_cpu_model

// [verification/test_single_cycle_8x8_multiplier.sv]
// Self-checking bench for the 8x8 multiplier
`timescale 1ns/1ns
module test_single_cycle_8x8_multiplier;
    import hmul_pkg::*;
    logic          i_clk_sys = 1'b0; // Core clock
    logic          i_reset   = 1'b1; // Synchronous reset
    hmul_byte_type w, f, d, hi, lo, fl;
    logic [3:0]    ctl;              // Go, write high, low, flags
    int            mismatches = 0;
    int            checked    = 0;
    // Core clock, 4 ns period
    always #2 i_clk_sys = ~i_clk_sys;
    hmul_cpu_model cpu (.i_clk_sys(i_clk_sys), .o_w(w), .o_f(f), .o_ctl(ctl), .o_d(d));
    hmul_core dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_mul_go(ctl[3]),
        .i_working_register(w), .i_file_operand(f), .i_wr_prod_hi(ctl[2]),
        .i_wr_prod_lo(ctl[1]), .i_wr_flags(ctl[0]), .i_wr_data(d),
        .o_product_high_byte(hi), .o_product_low_byte(lo), .o_alu_flag_register(fl));
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Multiply then idle; the pair shows the product on return
    task automatic mul(input hmul_byte_type a, b, output logic [15:0] p);
        cpu.op(4'h8, a, b, 8'h00);
        cpu.op(4'h0, 8'h00, 8'h00, 8'h00);
        p = {hi, lo};
    endtask : mul
    // Back-to-back multiplies, each checked one cycle later
    task automatic t_back();
        hmul_byte_type a[5] = '{8'hFF, 8'h00, 8'h80, 8'h01, 8'h0F};
        hmul_byte_type b[5] = '{8'hFF, 8'hC3, 8'h02, 8'h01, 8'h10};
        for (int i = 0; i < 6; i++)
        begin
            cpu.op(i < 5 ? 4'h8 : 4'h0, a[i % 5], b[i % 5], 8'h00);
            if (i > 0)
                chk("product", {hi, lo}, {8'h00, a[i-1]} * {8'h00, b[i-1]});
        end
    endtask : t_back
    // Flags survive a multiply, also one that carries a flag write
    task automatic t_flags();
        cpu.op(4'h1, 8'h00, 8'h00, 8'hA5);
        cpu.op(4'h9, 8'h12, 8'h34, 8'h5A);
        chk("flags", {8'h00, fl}, 16'h00A5);
        cpu.op(4'h0, 8'h00, 8'h00, 8'h00);
        chk("flags", {8'h00, fl}, 16'h00A5);
        chk("product", {hi, lo}, 16'h03A8);
    endtask : t_flags
    // Direct writes, holding while idle, writes lost to a multiply
    task automatic t_hold();
        cpu.op(4'h4, 8'h00, 8'h00, 8'h3C);
        cpu.op(4'h2, 8'h00, 8'h00, 8'hC3);
        repeat (5) cpu.op(4'h0, 8'h00, 8'h00, 8'h00);
        chk("pair", {hi, lo}, 16'h3CC3);
        cpu.op(4'hE, 8'h02, 8'h03, 8'hFF);
        cpu.op(4'h0, 8'h00, 8'h00, 8'h00);
        chk("pair", {hi, lo}, 16'h0006);
    endtask : t_hold
    // Software-built 16x16 and signed 8x8 products from partials
    task automatic t_soft();
        logic [15:0] ll, lh, hl, hh;
        logic [31:0] r;
        logic [31:0] s;
        mul(8'h23, 8'h7E, ll);
        mul(8'h23, 8'hFF, lh);
        mul(8'h81, 8'h7E, hl);
        mul(8'h81, 8'hFF, hh);
        r = {hh, 16'h0000} + {8'h00, lh, 8'h00} + {8'h00, hl, 8'h00} + {16'h0000, ll};
        chk("wide_result_bytes", r[31:16], 16'h80E1);
        chk("wide_result_bytes", r[15:0], 16'h6C3A);
        chk("signed", hl - {8'h7E, 8'h00}, 16'(-127 * 126));
        // Signed 16x16: both high bytes negative, so both shifted operands go
        s = r - {8'hFF, 8'h7E, 16'h0000} - {8'h81, 8'h23, 16'h0000};
        chk("signed_wide", s[31:16], 16'h0040);
        chk("signed_wide", s[15:0], 16'h6C3A);
    endtask : t_soft
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Watchdog: 5000 cycles, about a hundred times what the scenarios need
    initial
    begin
        #20000;
        mismatches++;
        tally_and_finish();
    end
    // Reset for 16 cycles, then every scenario in turn
    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        chk("reset", {hi, lo}, 16'h0000);
        t_back();
        t_flags();
        t_hold();
        t_soft();
        tally_and_finish();
    end
endmodule : test_single_cycle_8x8_multiplier
